// ---- mccj_exec.sv ----
/*
  Execution logic for watchdog clear, register clear, complement,
  decrement, decrement-and-skip, jump and increment, with an APB view of
  the status flags, page bits, prescaler assignment and jump target.
  Assumes the fetch stage offers one instruction per enabled cycle with
  the addressed file register already read, on the same clock.
*/
// Notes on behaviour
// RQ1: Watchdog clear restarts the watchdog counter from zero.
// RQ2: Watchdog clear also clears the prescaler when it serves the watchdog.
// RQ3: Watchdog clear sets the active-low time-out and power-down flags high.
// RQ4: Register clear writes zero to the file register and sets the zero flag.
// RQ5: Destination select zero writes the accumulator, one the file register.
// RQ6: Complement yields the inverted operand and updates the zero flag.
// RQ7: Decrement subtracts one and updates the zero flag.
// RQ8: Decrement-and-skip leaves flags alone and on zero discards the next op.
// RQ9: Jump loads its nine bits into the low counter bits, page bits above.
// RQ10: Jump always takes two cycles and leaves every flag unchanged.
// RQ11: Increment adds one and updates the zero flag.
// RQ12: Increment and decrement wrap modulo 256.
`timescale 1ns/1ps
module mccj_exec (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire mccj_pkg::mccj_instr_s instr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [7:0] result_out,
  output logic acc_we_out,
  output logic file_we_out,
  output logic [4:0] file_addr_out,
  output logic watchdog_clear_out,
  output logic prescaler_clear_out,
  output logic pc_load_out,
  output logic [10:0] pc_target_out,
  output logic discard_out,
  output logic zero_flag_out,
  output logic timeout_flag_n_out,
  output logic power_down_flag_n_out
);

  mccj_pkg::mccj_state_e state_r, state_nxt;
  logic [7:0] result_nxt;
  logic acc_we_nxt, file_we_nxt, wdt_clr_nxt, presc_clr_nxt;
  logic [4:0] file_addr_nxt;
  logic pc_load_nxt, discard_nxt;
  logic [10:0] pc_target_nxt;
  logic zero_nxt, to_n_nxt, pd_n_nxt;
  logic [1:0] page_r, page_nxt;
  logic presc_wdt_r, presc_wdt_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic exec_now, apb_write;
  logic [7:0] alu;

  assign exec_now = ce_in && state_r == mccj_pkg::ST_EXEC && instr_in.valid;
  assign apb_write = psel_in && penable_in && pready_out && pwrite_in;

  // Instruction execution and flags
  always_comb begin
    state_nxt = state_r;
    result_nxt = result_out;
    acc_we_nxt = 1'h0;
    file_we_nxt = 1'h0;
    file_addr_nxt = file_addr_out;
    wdt_clr_nxt = 1'h0;
    presc_clr_nxt = 1'h0;
    pc_load_nxt = 1'h0;
    pc_target_nxt = pc_target_out;
    discard_nxt = 1'h0;
    zero_nxt = zero_flag_out;
    to_n_nxt = timeout_flag_n_out;
    pd_n_nxt = power_down_flag_n_out;
    page_nxt = page_r;
    presc_wdt_nxt = presc_wdt_r;
    alu = mccj_pkg::BYTE_ZERO;
    // Software writes first so that an executing instruction wins
    if (apb_write && paddr_in == mccj_pkg::STATUS_OFFSET) begin
      zero_nxt = pwdata_in[mccj_pkg::ZERO_BIT];
      page_nxt = pwdata_in[mccj_pkg::PAGE_MSB:mccj_pkg::PAGE_LSB];
    end
    if (apb_write && paddr_in == mccj_pkg::CONTROL_OFFSET) begin
      presc_wdt_nxt = pwdata_in[mccj_pkg::PRESC_WDT_BIT];
    end
    if (ce_in && state_r == mccj_pkg::ST_FLUSH) begin
      state_nxt = mccj_pkg::ST_EXEC;
    end else if (exec_now) begin
      file_addr_nxt = instr_in.file_addr;
      case (instr_in.op)
        mccj_pkg::WATCHDOG_CLEAR_OP: begin
          wdt_clr_nxt = 1'h1; // RQ1
          presc_clr_nxt = presc_wdt_r; // RQ2
          to_n_nxt = 1'h1; // RQ3
          pd_n_nxt = 1'h1; // RQ3
        end
        mccj_pkg::REGISTER_CLEAR_OP: begin
          result_nxt = mccj_pkg::BYTE_ZERO; // RQ4
          file_we_nxt = 1'h1; // RQ4
          zero_nxt = 1'h1; // RQ4
        end
        mccj_pkg::COMPLEMENT_OP,
        mccj_pkg::DECREMENT_OP,
        mccj_pkg::DECREMENT_SKIP_ZERO_OP,
        mccj_pkg::INCREMENT_OP: begin
          if (instr_in.op == mccj_pkg::COMPLEMENT_OP) begin
            alu = ~instr_in.file_value; // RQ6
          end else if (instr_in.op == mccj_pkg::INCREMENT_OP) begin
            alu = instr_in.file_value + mccj_pkg::BYTE_ONE; // RQ11 RQ12
          end else begin
            alu = instr_in.file_value - mccj_pkg::BYTE_ONE; // RQ7 RQ12
          end
          result_nxt = alu;
          acc_we_nxt = instr_in.dest == mccj_pkg::DEST_ACC; // RQ5
          file_we_nxt = instr_in.dest == mccj_pkg::DEST_FILE; // RQ5
          if (instr_in.op == mccj_pkg::DECREMENT_SKIP_ZERO_OP) begin
            if (alu == mccj_pkg::BYTE_ZERO) begin
              discard_nxt = 1'h1; // RQ8
              state_nxt = mccj_pkg::ST_FLUSH; // RQ8
            end
          end else begin
            zero_nxt = alu == mccj_pkg::BYTE_ZERO; // RQ6 RQ7 RQ11
          end
        end
        mccj_pkg::JUMP_OP: begin
          pc_load_nxt = 1'h1; // RQ9
          pc_target_nxt = {page_r, instr_in.target}; // RQ9
          discard_nxt = 1'h1; // RQ10
          state_nxt = mccj_pkg::ST_FLUSH; // RQ10
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_r <= mccj_pkg::ST_EXEC;
      result_out <= mccj_pkg::BYTE_ZERO;
      acc_we_out <= 1'h0;
      file_we_out <= 1'h0;
      file_addr_out <= 5'h00;
      watchdog_clear_out <= 1'h0;
      prescaler_clear_out <= 1'h0;
      pc_load_out <= 1'h0;
      pc_target_out <= mccj_pkg::PC_RST;
      discard_out <= 1'h0;
      zero_flag_out <= mccj_pkg::ZERO_RST;
      timeout_flag_n_out <= mccj_pkg::TO_N_RST;
      power_down_flag_n_out <= mccj_pkg::PD_N_RST;
      page_r <= mccj_pkg::PAGE_RST;
      presc_wdt_r <= mccj_pkg::PRESC_WDT_RST;
    end else if (ce_in) begin
      state_r <= state_nxt;
      result_out <= result_nxt;
      acc_we_out <= acc_we_nxt;
      file_we_out <= file_we_nxt;
      file_addr_out <= file_addr_nxt;
      watchdog_clear_out <= wdt_clr_nxt;
      prescaler_clear_out <= presc_clr_nxt;
      pc_load_out <= pc_load_nxt;
      pc_target_out <= pc_target_nxt;
      discard_out <= discard_nxt;
      zero_flag_out <= zero_nxt;
      timeout_flag_n_out <= to_n_nxt;
      power_down_flag_n_out <= pd_n_nxt;
      page_r <= page_nxt;
      presc_wdt_r <= presc_wdt_nxt;
    end
  end

  // APB slave: one wait cycle, then pready with data
  always_comb begin
    pready_nxt = psel_in && penable_in && !pready_out;
    pslverr_nxt = 1'h0;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt) begin
      case (paddr_in)
        mccj_pkg::STATUS_OFFSET: begin
          prdata_nxt[mccj_pkg::ZERO_BIT] = zero_flag_out;
          prdata_nxt[mccj_pkg::PD_BIT] = power_down_flag_n_out;
          prdata_nxt[mccj_pkg::TO_BIT] = timeout_flag_n_out;
          prdata_nxt[mccj_pkg::PAGE_MSB:mccj_pkg::PAGE_LSB] = page_r;
        end
        mccj_pkg::CONTROL_OFFSET: begin
          prdata_nxt[mccj_pkg::PRESC_WDT_BIT] = presc_wdt_r;
        end
        mccj_pkg::PC_OFFSET: begin
          prdata_nxt[10:0] = pc_target_out;
        end
        default: begin
          pslverr_nxt = 1'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'h0;
      pslverr_out <= 1'h0;
    end else if (ce_in) begin
      prdata_out <= prdata_nxt;
      pready_out <= pready_nxt;
      pslverr_out <= pslverr_nxt;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence wdt_op_s;
    exec_now && instr_in.op == mccj_pkg::WATCHDOG_CLEAR_OP;
  endsequence
  sequence skip_zero_s;
    exec_now && !apb_write && instr_in.op == mccj_pkg::DECREMENT_SKIP_ZERO_OP
      && instr_in.file_value == mccj_pkg::BYTE_ONE;
  endsequence
  sequence flush_s;
    discard_out && state_r == mccj_pkg::ST_FLUSH;
  endsequence

  wdt_restart_a: assert property (wdt_op_s |=> watchdog_clear_out) // RQ1
    else $error("watchdog clear did not pulse");
  presc_gate_a: assert property ( // RQ2
    prescaler_clear_out |-> watchdog_clear_out && presc_wdt_r)
    else $error("prescaler cleared while not assigned");
  wdt_flags_a: assert property ( // RQ3
    wdt_op_s |=> timeout_flag_n_out && power_down_flag_n_out)
    else $error("flags not set by watchdog clear");
  reg_clear_a: assert property ( // RQ4
    exec_now && instr_in.op == mccj_pkg::REGISTER_CLEAR_OP |=>
    file_we_out && result_out == mccj_pkg::BYTE_ZERO && zero_flag_out)
    else $error("register clear wrong");
  dest_select_a: assert property ( // RQ5
    exec_now && instr_in.op inside {mccj_pkg::COMPLEMENT_OP,
    mccj_pkg::DECREMENT_OP, mccj_pkg::DECREMENT_SKIP_ZERO_OP,
    mccj_pkg::INCREMENT_OP} |=> acc_we_out == !$past(instr_in.dest)
    && file_we_out == $past(instr_in.dest))
    else $error("destination select wrong");
  compl_value_a: assert property ( // RQ6
    exec_now && instr_in.op == mccj_pkg::COMPLEMENT_OP |=>
    result_out == ~$past(instr_in.file_value)
    && zero_flag_out == (result_out == mccj_pkg::BYTE_ZERO))
    else $error("complement wrong");
  dec_value_a: assert property ( // RQ7
    exec_now && instr_in.op == mccj_pkg::DECREMENT_OP |=>
    result_out == $past(instr_in.file_value) - mccj_pkg::BYTE_ONE
    && zero_flag_out == (result_out == mccj_pkg::BYTE_ZERO))
    else $error("decrement wrong");
  skip_discard_a: assert property ( // RQ8
    skip_zero_s |=> flush_s and $stable(zero_flag_out))
    else $error("skip on zero not taken");
  skip_none_a: assert property ( // RQ8
    exec_now && instr_in.op == mccj_pkg::DECREMENT_SKIP_ZERO_OP
    && instr_in.file_value != mccj_pkg::BYTE_ONE |=>
    !discard_out && state_r == mccj_pkg::ST_EXEC)
    else $error("skip taken on nonzero result");
  flush_drop_a: assert property ( // RQ8 RQ10
    ce_in && state_r == mccj_pkg::ST_FLUSH |=>
    !acc_we_out && !file_we_out && !pc_load_out && !discard_out)
    else $error("discarded op was executed");
  jump_target_a: assert property ( // RQ9
    exec_now && instr_in.op == mccj_pkg::JUMP_OP |=> pc_load_out
    && pc_target_out == {$past(page_r), $past(instr_in.target)})
    else $error("jump target wrong");
  jump_two_a: assert property ( // RQ10
    exec_now && instr_in.op == mccj_pkg::JUMP_OP && !apb_write ##1 ce_in
    |-> (flush_s and $stable(zero_flag_out))
    ##1 state_r == mccj_pkg::ST_EXEC && !pc_load_out)
    else $error("jump not two cycles");
  inc_value_a: assert property ( // RQ11
    exec_now && instr_in.op == mccj_pkg::INCREMENT_OP |=>
    result_out == $past(instr_in.file_value) + mccj_pkg::BYTE_ONE
    && zero_flag_out == (result_out == mccj_pkg::BYTE_ZERO))
    else $error("increment wrong");
  wrap_mod_a: assert property ( // RQ12
    exec_now && instr_in.op == mccj_pkg::INCREMENT_OP
    && instr_in.file_value == 8'hFF |=>
    result_out == mccj_pkg::BYTE_ZERO && zero_flag_out)
    else $error("increment did not wrap");
  dec_wrap_a: assert property ( // RQ12
    exec_now && instr_in.op == mccj_pkg::DECREMENT_OP
    && instr_in.file_value == mccj_pkg::BYTE_ZERO |=>
    result_out == 8'hFF && !zero_flag_out)
    else $error("decrement did not wrap");
  ce_freeze_a: assert property (
    !ce_in |=> $stable(state_r) && $stable(result_out)
    && $stable(pready_out) && $stable(zero_flag_out))
    else $error("state moved while clock enable low");
  apb_wait_a: assert property (
    ce_in && psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready not raised after one wait");

endmodule

// ---- mccj_pkg.sv ----
/*
  Shared constants, types and the register map of the clear, count and
  jump execution block.
  Assumes one core clock; all users name items as mccj_pkg::name.
*/
package mccj_pkg;

  // Operations handled by this block
  typedef enum logic [2:0] {
    NOP_OP                 = 3'h0,
    WATCHDOG_CLEAR_OP      = 3'h1,
    REGISTER_CLEAR_OP      = 3'h2,
    COMPLEMENT_OP          = 3'h3,
    DECREMENT_OP           = 3'h4,
    DECREMENT_SKIP_ZERO_OP = 3'h5,
    JUMP_OP                = 3'h6,
    INCREMENT_OP           = 3'h7
  } mccj_op_e;

  // Execute, then a flush cycle after a jump or a taken skip
  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_FLUSH = 2'h1
  } mccj_state_e;

  // One instruction offered by the fetch stage
  typedef struct packed {
    logic       valid;
    mccj_op_e   op;
    logic       dest;
    logic [4:0] file_addr;
    logic [7:0] file_value;
    logic [8:0] target;
  } mccj_instr_s;

  // Destination select encodings
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // Register map, byte addresses
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] PC_OFFSET = 8'h08;

  // Status field positions
  localparam int ZERO_BIT = 2;
  localparam int PD_BIT = 3;
  localparam int TO_BIT = 4;
  localparam int PAGE_LSB = 5;
  localparam int PAGE_MSB = 6;
  // Control field position
  localparam int PRESC_WDT_BIT = 0;

  // Values after reset
  localparam logic ZERO_RST = 1'h0;
  localparam logic TO_N_RST = 1'h1;
  localparam logic PD_N_RST = 1'h1;
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam logic PRESC_WDT_RST = 1'h0;
  localparam logic [10:0] PC_RST = 11'h000;

  // Operand constants
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
endpackage

// ---- mccj_testbench.sv ----
/*
  Self-checking bench for the clear, count and jump execution block.
  Assumes mccj_pkg and mccj_exec are compiled first; bench drives all ports.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic clk_in = 1'b0;
  logic ce = 1'b1;
  logic rst_n_in = 1'b0;
  mccj_pkg::mccj_instr_s instr = '0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] result;
  logic acc_we, file_we, wd_clr, ps_clr, pc_load, discard;
  logic zero, to_n, pd_n;
  logic [4:0] faddr;
  logic [10:0] pc_t;
  int error_cnt = 0;
  int samples_checked = 0;
  mccj_exec i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .instr_in(instr), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .result_out(result),
    .acc_we_out(acc_we), .file_we_out(file_we), .file_addr_out(faddr),
    .watchdog_clear_out(wd_clr), .prescaler_clear_out(ps_clr),
    .pc_load_out(pc_load), .pc_target_out(pc_t), .discard_out(discard),
    .zero_flag_out(zero), .timeout_flag_n_out(to_n),
    .power_down_flag_n_out(pd_n));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One APB transfer; answer, read data and error taken at the same edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Offer one instruction, then look at its answer one cycle later
  task automatic do_op(input mccj_pkg::mccj_op_e op, input logic d,
                       input logic [7:0] v);
    @(posedge clk_in);
    instr <= '{1'b1, op, d, v[4:0], v, {1'b1, v}};
    @(posedge clk_in);
    instr.valid <= 1'b0;
    #1;
  endtask
  typedef struct {
    mccj_pkg::mccj_op_e op;
    logic [7:0] v;
    logic [7:0] r;
    logic z;
  } mccj_vec_s;
  mccj_vec_s tbl[4] = '{
    '{mccj_pkg::DECREMENT_OP, 8'h00, 8'hFF, 1'b0},
    '{mccj_pkg::DECREMENT_OP, 8'h01, 8'h00, 1'b1},
    '{mccj_pkg::INCREMENT_OP, 8'hFF, 8'h00, 1'b1},
    '{mccj_pkg::INCREMENT_OP, 8'h10, 8'h11, 1'b0}};
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, mccj_pkg::STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_0018)
    apb(1'b0, mccj_pkg::CONTROL_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    do_op(mccj_pkg::REGISTER_CLEAR_OP, 1'b1, 8'h37);
    `CHK({result, file_we, zero, faddr}, {8'h00, 1'b1, 1'b1, 5'h17})
    do_op(mccj_pkg::COMPLEMENT_OP, 1'b1, 8'h5A);
    `CHK({result, file_we, acc_we, zero}, {8'hA5, 3'b100})
    do_op(mccj_pkg::COMPLEMENT_OP, 1'b0, 8'hFF);
    `CHK({result, file_we, acc_we, zero}, {8'h00, 3'b011})
    for (int i = 0; i < 4; i++) begin
      do_op(tbl[i].op, i[0], tbl[i].v);
      `CHK({result, zero}, {tbl[i].r, tbl[i].z})
      `CHK({acc_we, file_we}, {~i[0], i[0]})
    end
    do_op(mccj_pkg::WATCHDOG_CLEAR_OP, 1'b0, 8'h00);
    `CHK({wd_clr, ps_clr}, 2'b10)
    `CHK({to_n, pd_n}, 2'b11)
    apb(1'b1, mccj_pkg::CONTROL_OFFSET, 32'h1);
    do_op(mccj_pkg::WATCHDOG_CLEAR_OP, 1'b0, 8'h00);
    `CHK({wd_clr, ps_clr, to_n, pd_n}, 4'hF)
    apb(1'b1, mccj_pkg::STATUS_OFFSET, 32'h64);
    apb(1'b0, mccj_pkg::STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_007C)
    do_op(mccj_pkg::DECREMENT_SKIP_ZERO_OP, 1'b0, 8'h05);
    `CHK({result, acc_we, discard, zero}, {8'h04, 3'b101})
    do_op(mccj_pkg::DECREMENT_SKIP_ZERO_OP, 1'b1, 8'h01);
    `CHK({result, file_we, discard, zero}, {8'h00, 3'b111})
    // Jump followed at once by an op that must be dropped
    @(posedge clk_in);
    instr <= '{1'b1, mccj_pkg::JUMP_OP, 1'b0, 5'h00, 8'h00, 9'h1FF};
    @(posedge clk_in);
    instr <= '{1'b1, mccj_pkg::INCREMENT_OP, 1'b0, 5'h01, 8'h20, 9'h0};
    #1;
    `CHK({pc_load, discard, pc_t}, {2'b11, 11'h7FF})
    `CHK({zero, to_n, pd_n}, 3'b111)
    @(posedge clk_in);
    instr.valid <= 1'b0;
    #1;
    `CHK({acc_we, file_we, pc_load, result}, {3'b000, 8'h00})
    apb(1'b0, mccj_pkg::PC_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_07FF)
    // Clock enable low: the offered op waits until it is raised
    @(posedge clk_in);
    ce <= 1'b0;
    instr <= '{1'b1, mccj_pkg::INCREMENT_OP, 1'b0, 5'h02, 8'h41, 9'h000};
    repeat (2) @(posedge clk_in);
    #1;
    `CHK({acc_we, result}, {1'b0, 8'h00})
    @(posedge clk_in);
    ce <= 1'b1;
    @(posedge clk_in);
    instr.valid <= 1'b0;
    #1;
    `CHK({acc_we, file_we, result, zero}, {2'b10, 8'h42, 1'b0})
    // Reset in mid-run returns page and zero to their reset values
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, mccj_pkg::STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h0000_0018)
    complete_run();
  end
endmodule
